// ---- verilog/dmsc_pkg.sv ----
// Package with constants and types of the drive mode and setup control block
package dmsc_pkg;
  // Operating mode codes written by the master
  localparam logic [7:0] MODE_AUTOSETUP = 8'hfe;
  localparam logic [7:0] MODE_VELOCITY  = 8'h02;
  localparam logic [7:0] MODE_CLKDIR    = 8'hf6;  // Internal code, not master visible
  // Control word fields
  localparam int CW_OP_MODE_SPECIFIC_BIT = 4;
  localparam logic [3:0] CW_ENABLE_OP = 4'hf;
  localparam logic [15:0] CW_STOP = 16'h0000;
  // Status word fields
  localparam int SW_OP_EN_BIT    = 2;
  localparam int SW_INDEX_BIT    = 10;
  localparam int SW_SETUP_DONE_BIT = 12;
  // Special mode configuration
  localparam logic [7:0] SPEC_ACTIVATE = 8'h02;
  localparam logic [3:0] SPEC_CODE_MAX = 4'hf;
  localparam int SPEC_LOOP_BIT   = 3;   // 0: open loop, 1: closed loop
  localparam int SPEC_SLOW_BIT   = 0;   // Odd analog code: 100 rpm maximum
  localparam int SPEC_JOY_BIT    = 1;
  localparam logic [7:0] SPEC_RESET_ACT  = 8'h00;
  localparam logic [3:0] SPEC_RESET_CODE = 4'h0;
  // Fixed speeds in rpm
  localparam logic [15:0] TEST_RUN_RPM  = 16'd30;
  localparam logic [15:0] ANALOG_FAST_RPM = 16'd1000;
  localparam logic [15:0] ANALOG_SLOW_RPM = 16'd100;
  // Storage categories
  localparam logic [7:0] STORE_DRIVE  = 8'h05;
  localparam logic [7:0] STORE_TUNING = 8'h06;
  // Parameter memory layout, one word per measured quantity
  localparam int PAR_AW = 3;
  localparam int PAR_DW = 32;

  typedef enum logic [2:0] {
    MEAS_MOTOR_TYPE, MEAS_RESISTANCE, MEAS_INDUCTANCE, MEAS_FLUX,
    MEAS_ENC_RES, MEAS_ALIGN, MEAS_HALL, MEAS_NONE
  } dmsc_meas_t;

  typedef enum logic [2:0] {
    DRV_OFF, DRV_VELOCITY, DRV_CLKDIR, DRV_TEST_RUN, DRV_ANALOG, DRV_SETUP
  } dmsc_drive_t;

  typedef struct packed {
    logic        active;
    logic        closed_loop;
    dmsc_drive_t kind;
    logic        joystick;
    logic [15:0] max_rpm;
  } dmsc_spec_t;

  typedef struct packed {
    logic            enable;
    logic            dir_cw;
    logic            step;
    logic [15:0]     fixed_rpm;
  } dmsc_motor_t;
endpackage

// ---- verilog/dmsc_param_mem.sv ----
// Small memory holding the measured setup parameters, registered read port
`timescale 1ns/1ps
`default_nettype none
module dmsc_param_mem #(
  parameter int AW = 3,
  parameter int DW = 32
) (
  // Clock
  input  wire logic          i_clk,
  // Write port
  input  wire logic          i_wr,
  input  wire logic [AW-1:0] i_wr_addr,
  input  wire logic [DW-1:0] i_wr_data,
  // Read port
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [DW-1:0] o_rd_data
);
  logic [DW-1:0] mem_ff [2**AW];

  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem_ff[i_wr_addr] <= i_wr_data;
    end
  end

  // No reset so the array maps onto plain RAM
  always_ff @(posedge i_clk) begin
    o_rd_data <= mem_ff[i_rd_addr];
  end
endmodule
`default_nettype wire

// ---- verilog/dmsc_top.sv ----
// Mode control: automatic setup, velocity test run and special drive modes
`timescale 1ns/1ps
`default_nettype none
module dmsc_top
  import dmsc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Object writes from the fieldbus side
  input  wire logic              i_mode_wr,
  input  wire logic [7:0]        i_mode_data,
  input  wire logic              i_cw_wr,
  input  wire logic [15:0]       i_cw_data,
  input  wire logic              i_spec_act_wr,
  input  wire logic [7:0]        i_spec_act_data,
  input  wire logic              i_spec_code_wr,
  input  wire logic [7:0]        i_spec_code_data,
  input  wire logic              i_restart,
  input  wire logic              i_user_prog_run,
  // Sensor presence
  input  wire logic              i_enc_present,
  input  wire logic              i_enc_has_index,
  input  wire logic              i_hall_present,
  // Measurement engine
  input  wire logic              i_meas_valid,
  input  wire logic [PAR_DW-1:0] i_meas_data,
  input  wire logic              i_index_seen,
  output dmsc_meas_t             o_meas_req,
  // Digital pins: enable (input 3), clock, direction
  input  wire logic              i_pin_enable,
  input  wire logic              i_pin_clock,
  input  wire logic              i_pin_dir,
  // Parameter readback
  input  wire logic [PAR_AW-1:0] i_param_rd_addr,
  output logic      [PAR_DW-1:0] o_param_rd_data,
  // Status and drive outputs
  output logic      [15:0]       o_status_word,
  output logic      [7:0]        o_mode_eff,
  output dmsc_spec_t             o_spec,
  output dmsc_motor_t            o_motor,
  output logic                   o_coord_invalid,
  output logic                   o_store_req,
  output logic      [7:0]        o_store_cat,
  output logic                   o_cfg_save_req
);
  typedef enum logic [1:0] { ST_IDLE, ST_MEAS, ST_STORE, ST_DONE } dmsc_state_t;

  // Pin synchronisers; stage one is read only by stage two
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic       clk_d_ff;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          pin_s1_ff[g] <= 1'b0;
          pin_s2_ff[g] <= 1'b0;
        end else begin
          pin_s1_ff[g] <= (g == 0) ? i_pin_enable : (g == 1) ? i_pin_clock : i_pin_dir;
          pin_s2_ff[g] <= pin_s1_ff[g];
        end
      end
    end
  endgenerate
  wire logic en_pin  = pin_s2_ff[0];
  wire logic clk_pin = pin_s2_ff[1];
  wire logic dir_pin = pin_s2_ff[2];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_d_ff <= 1'b0;
    end else begin
      clk_d_ff <= clk_pin;
    end
  end

  // Special mode configuration: stored copy and the copy in effect
  logic [7:0] spec_act_st_ff;
  logic [3:0] spec_code_st_ff;
  logic       spec_on_ff;
  logic [3:0] spec_code_ff;
  logic       cfg_save_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      spec_act_st_ff  <= SPEC_RESET_ACT;
      spec_code_st_ff <= SPEC_RESET_CODE;
      cfg_save_ff     <= 1'b0;
    end else begin
      cfg_save_ff <= 1'b0;
      if (i_spec_act_wr) begin
        spec_act_st_ff <= i_spec_act_data;
        cfg_save_ff    <= 1'b1;
      end
      // Codes beyond 0F are refused and leave the stored code unchanged
      if (i_spec_code_wr && (i_spec_code_data <= {4'h0, SPEC_CODE_MAX})) begin
        spec_code_st_ff <= i_spec_code_data[3:0];
        cfg_save_ff     <= 1'b1;
      end
    end
  end

  // Configuration only becomes live on a restart
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      spec_on_ff   <= 1'b0;
      spec_code_ff <= SPEC_RESET_CODE;
    end else if (i_restart) begin
      spec_on_ff   <= (spec_act_st_ff == SPEC_ACTIVATE);
      spec_code_ff <= spec_code_st_ff;
    end
  end

  // Decode of the live special code
  dmsc_spec_t spec;
  always_comb begin
    spec             = '0;
    spec.active      = spec_on_ff;
    spec.closed_loop = spec_code_ff[SPEC_LOOP_BIT];
    spec.joystick    = 1'b0;
    spec.max_rpm     = 16'h0000;
    case (spec_code_ff[2:1])
      2'b00: begin
        spec.kind = DRV_CLKDIR;
      end
      2'b01: begin
        spec.kind    = DRV_TEST_RUN;
        spec.max_rpm = TEST_RUN_RPM;
      end
      default: begin
        spec.kind     = DRV_ANALOG;
        spec.joystick = spec_code_ff[SPEC_JOY_BIT];
        spec.max_rpm  = spec_code_ff[SPEC_SLOW_BIT] ? ANALOG_SLOW_RPM : ANALOG_FAST_RPM;
      end
    endcase
    if (!spec_on_ff) begin
      spec.kind = DRV_OFF;
    end
  end

  // Modes of operation object
  logic [7:0] mode_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_ff <= 8'h00;
    end else if (i_mode_wr) begin
      mode_ff <= i_mode_data;
    end
  end

  // Power state: operation enabled or not
  logic op_en_ff;
  logic op_mode_specific_d_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      op_en_ff <= 1'b0;
    end else if (spec_on_ff) begin
      op_en_ff <= en_pin;
    end else if (i_cw_wr) begin
      if (i_cw_data == CW_STOP) begin
        op_en_ff <= 1'b0;
      end else if (i_cw_data[3:0] == CW_ENABLE_OP) begin
        op_en_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      op_mode_specific_d_ff <= 1'b0;
    end else if (i_cw_wr) begin
      op_mode_specific_d_ff <= i_cw_data[CW_OP_MODE_SPECIFIC_BIT];
    end
  end

  // The master must already be in operation enabled when bit 4 rises
  // A start written while a run is busy is refused, so it never races the done flags
  dmsc_state_t state_ff;
  wire logic   setup_start = i_cw_wr && i_cw_data[CW_OP_MODE_SPECIFIC_BIT]
                           && !op_mode_specific_d_ff
                           && op_en_ff
                           && (mode_ff == MODE_AUTOSETUP)
                           && !i_user_prog_run
                           && !spec_on_ff
                           && ((state_ff == ST_IDLE) || (state_ff == ST_DONE));

  // Setup sequencer
  dmsc_meas_t  meas_ff;
  logic        done_ff;
  logic        idx_found_ff;
  logic        idx_seen_ff;
  logic        store_cnt_ff;
  logic        coord_bad_ff;

  function automatic dmsc_meas_t next_meas(input dmsc_meas_t cur, input logic enc_idx,
                                           input logic hall);
    dmsc_meas_t n;
    n = MEAS_NONE;
    case (cur)
      MEAS_MOTOR_TYPE: n = MEAS_RESISTANCE;
      MEAS_RESISTANCE: n = MEAS_INDUCTANCE;
      MEAS_INDUCTANCE: n = MEAS_FLUX;
      MEAS_FLUX:       n = enc_idx ? MEAS_ENC_RES : (hall ? MEAS_HALL : MEAS_NONE);
      MEAS_ENC_RES:    n = MEAS_ALIGN;
      MEAS_ALIGN:      n = hall ? MEAS_HALL : MEAS_NONE;
      default:         n = MEAS_NONE;
    endcase
    return n;
  endfunction

  wire logic enc_idx = i_enc_present && i_enc_has_index;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      meas_ff  <= MEAS_NONE;
    end else begin
      case (state_ff)
        ST_IDLE, ST_DONE: begin
          if (setup_start) begin
            state_ff <= ST_MEAS;
            meas_ff  <= MEAS_MOTOR_TYPE;
          end
        end
        ST_MEAS: begin
          if (!op_en_ff) begin
            // Abort without storing when the drive is disabled mid-run
            state_ff <= ST_IDLE;
            meas_ff  <= MEAS_NONE;
          end else if (i_meas_valid) begin
            meas_ff <= next_meas(meas_ff, enc_idx, i_hall_present);
            if (next_meas(meas_ff, enc_idx, i_hall_present) == MEAS_NONE) begin
              state_ff <= ST_STORE;
            end
          end
        end
        ST_STORE: begin
          if (store_cnt_ff) begin
            state_ff <= ST_DONE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Two store requests: drive category then tuning category
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      store_cnt_ff <= 1'b0;
    end else if (state_ff == ST_STORE) begin
      store_cnt_ff <= ~store_cnt_ff;
    end else begin
      store_cnt_ff <= 1'b0;
    end
  end

  // Index seen during the alignment run only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idx_seen_ff <= 1'b0;
    end else if (setup_start) begin
      idx_seen_ff <= 1'b0;
    end else if ((state_ff == ST_MEAS) && (meas_ff == MEAS_ALIGN) && i_index_seen) begin
      idx_seen_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_ff      <= 1'b0;
      idx_found_ff <= 1'b0;
    end else if (setup_start) begin
      done_ff      <= 1'b0;
      idx_found_ff <= 1'b0;
    end else if ((state_ff == ST_STORE) && store_cnt_ff) begin
      done_ff      <= 1'b1;
      idx_found_ff <= idx_seen_ff;
    end
  end

  // Coordinates stay invalid from setup completion until a restart
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      coord_bad_ff <= 1'b0;
    end else if ((state_ff == ST_STORE) && store_cnt_ff) begin
      coord_bad_ff <= 1'b1;
    end else if (i_restart) begin
      coord_bad_ff <= 1'b0;
    end
  end

  dmsc_param_mem #(
    .AW (PAR_AW),
    .DW (PAR_DW)
  ) u_param_mem (
    .i_clk     (i_clk),
    .i_wr      ((state_ff == ST_MEAS) && i_meas_valid && op_en_ff),
    .i_wr_addr (meas_ff),
    .i_wr_data (i_meas_data),
    .i_rd_addr (i_param_rd_addr),
    .o_rd_data (o_param_rd_data)
  );

  // Drive outputs
  dmsc_motor_t motor_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      motor_ff <= '0;
    end else begin
      motor_ff.enable    <= op_en_ff;
      motor_ff.step      <= 1'b0;
      motor_ff.dir_cw    <= 1'b1;
      motor_ff.fixed_rpm <= 16'h0000;
      if (spec_on_ff) begin
        case (spec.kind)
          DRV_CLKDIR: begin
            motor_ff.step   <= op_en_ff && clk_pin && !clk_d_ff;
            motor_ff.dir_cw <= !dir_pin;
          end
          DRV_TEST_RUN: begin
            motor_ff.fixed_rpm <= op_en_ff ? TEST_RUN_RPM : 16'h0000;
            motor_ff.dir_cw    <= !spec_code_ff[0];
          end
          DRV_ANALOG: begin
            // Absent direction signal reads low and gives clockwise
            motor_ff.dir_cw <= spec.joystick ? 1'b1 : !dir_pin;
          end
          default: begin
            motor_ff.dir_cw <= 1'b1;
          end
        endcase
      end
    end
  end

  logic [7:0] mode_eff_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_eff_ff <= 8'h00;
    end else if (spec_on_ff && (spec.kind == DRV_CLKDIR)) begin
      mode_eff_ff <= MODE_CLKDIR;
    end else if (spec_on_ff) begin
      mode_eff_ff <= MODE_VELOCITY;
    end else begin
      mode_eff_ff <= mode_ff;
    end
  end

  logic [15:0] sw_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sw_ff <= 16'h0000;
    end else begin
      sw_ff                    <= 16'h0000;
      sw_ff[SW_OP_EN_BIT]      <= op_en_ff;
      sw_ff[SW_INDEX_BIT]      <= idx_found_ff;
      sw_ff[SW_SETUP_DONE_BIT] <= done_ff;
    end
  end

  assign o_status_word   = sw_ff;
  assign o_mode_eff      = mode_eff_ff;
  assign o_spec          = spec;
  assign o_motor         = motor_ff;
  assign o_coord_invalid = coord_bad_ff;
  assign o_meas_req      = (state_ff == ST_MEAS) ? meas_ff : MEAS_NONE;
  assign o_store_req     = (state_ff == ST_STORE);
  assign o_store_cat     = store_cnt_ff ? STORE_TUNING : STORE_DRIVE;
  assign o_cfg_save_req  = cfg_save_ff;
endmodule
`default_nettype wire

// ---- bench/dmsc_checker.sv ----
// Port assertions for the mode control block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module dmsc_checker
  import dmsc_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // Inputs watched
  input wire logic        i_cw_wr,
  input wire logic [15:0] i_cw_data,
  input wire logic        i_spec_act_wr,
  input wire logic        i_restart,
  input wire logic        i_enc_present,
  input wire logic        i_enc_has_index,
  input wire logic        i_hall_present,
  input wire logic        i_meas_valid,
  input wire logic        i_pin_enable,
  // Outputs watched
  input wire dmsc_meas_t  o_meas_req,
  input wire logic [15:0] o_status_word,
  input wire dmsc_spec_t  o_spec,
  input wire dmsc_motor_t o_motor,
  input wire logic        o_store_req,
  input wire logic [7:0]  o_store_cat,
  input wire logic        o_cfg_save_req
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_store;
    o_store_req && o_store_cat == STORE_DRIVE ##1 o_store_req && o_store_cat == STORE_TUNING;
  endsequence

  a_store_order: assert property ($rose(o_store_req) |-> s_store)
    else $error("store categories out of order");
  a_done_after_store: assert property (s_store |-> ##[1:3] o_status_word[SW_SETUP_DONE_BIT])
    else $error("setup done flag missing after store");
  a_index_needs_done: assert property (o_status_word[SW_INDEX_BIT] |-> o_status_word[SW_SETUP_DONE_BIT])
    else $error("index flag without finished setup");
  a_enc_skipped: assert property (o_meas_req == MEAS_FLUX && i_meas_valid && !i_cw_wr
    && !(i_enc_present && i_enc_has_index) |=> o_meas_req != MEAS_ENC_RES)
    else $error("encoder measured without indexed encoder");
  a_hall_only: assert property (o_meas_req == MEAS_HALL |-> i_hall_present)
    else $error("hall measured without sensor");
  a_stop_on_zero: assert property (i_cw_wr && i_cw_data == CW_STOP && !o_spec.active
    |-> ##2 !o_motor.enable)
    else $error("motor still driven after zero control word");
  a_enable_follows: assert property ((o_spec.active && i_pin_enable) [*5]
    |-> o_status_word[SW_OP_EN_BIT])
    else $error("enable pin did not enable operation");
  a_disable_stops: assert property ((o_spec.active && !i_pin_enable) [*5]
    |-> !o_status_word[SW_OP_EN_BIT] && !o_motor.enable)
    else $error("motor driven with enable pin low");
  a_cfg_saved: assert property (i_spec_act_wr |=> o_cfg_save_req)
    else $error("config write not saved");
  a_cfg_deferred: assert property (!i_restart |=> $stable(o_spec))
    else $error("special config changed without restart");
  a_step_single: assert property (o_motor.step |=> !o_motor.step)
    else $error("step pulse longer than one cycle");
endmodule

bind dmsc_top dmsc_checker dmsc_checker_i (
  .i_clk, .i_rst, .i_cw_wr, .i_cw_data, .i_spec_act_wr, .i_restart, .i_enc_present,
  .i_enc_has_index, .i_hall_present, .i_meas_valid, .i_pin_enable, .o_meas_req,
  .o_status_word, .o_spec, .o_motor, .o_store_req, .o_store_cat, .o_cfg_save_req
);
`default_nettype wire

// ---- bench/dmsc_master_model.sv ----
// Fieldbus master model writing the mode, control and config objects
`timescale 1ns/1ps
`default_nettype none
module dmsc_master_model (
  // Clock
  input  wire logic   i_clk,
  // Object writes
  output logic        o_mode_wr,
  output logic [7:0]  o_mode_data,
  output logic        o_cw_wr,
  output logic [15:0] o_cw_data,
  output logic        o_act_wr,
  output logic [7:0]  o_act_data,
  output logic        o_code_wr,
  output logic [7:0]  o_code_data,
  output logic        o_restart,
  output logic        o_user_prog_run
);
  initial begin
    {o_mode_wr, o_cw_wr, o_act_wr, o_code_wr, o_restart, o_user_prog_run} = '0;
    {o_mode_data, o_cw_data, o_act_data, o_code_data} = '0;
  end

  // Kind 5 writes the user program flag, a level rather than a strobe
  task automatic put(input int k, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_mode_data = d[7:0];
    o_cw_data = d;
    o_act_data = d[7:0];
    o_code_data = d[7:0];
    o_mode_wr = (k == 0);
    o_cw_wr = (k == 1);
    o_act_wr = (k == 2);
    o_code_wr = (k == 3);
    o_restart = (k == 4);
    if (k == 5) o_user_prog_run = d[0];
    @(posedge i_clk);
    #1;
    {o_mode_wr, o_cw_wr, o_act_wr, o_code_wr, o_restart} = '0;
    // Stale data would hide a design that samples without its strobe
    o_mode_data = ~d[7:0];
    o_cw_data = ~d;
    o_act_data = ~d[7:0];
    o_code_data = ~d[7:0];
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_drive_mode_setup_control.sv ----
// Self-checking bench for the drive mode and setup control block
`timescale 1ns/1ps
`default_nettype none
module tb_drive_mode_setup_control
  import dmsc_pkg::*;
();
  logic        i_clk, i_rst, i_mode_wr, i_cw_wr, i_spec_act_wr, i_spec_code_wr, i_restart;
  logic        i_user_prog_run, i_enc_present, i_enc_has_index, i_hall_present;
  logic        i_meas_valid, i_index_seen, i_pin_enable, i_pin_clock, i_pin_dir;
  logic        o_coord_invalid, o_store_req, o_cfg_save_req;
  logic [2:0]  i_param_rd_addr;
  logic [3:0]  cv;
  logic [7:0]  i_mode_data, i_spec_act_data, i_spec_code_data, o_mode_eff, o_store_cat;
  logic [15:0] i_cw_data, o_status_word;
  logic [31:0] i_meas_data, o_param_rd_data;
  logic [31:0] par [8];
  dmsc_meas_t  o_meas_req;
  dmsc_spec_t  o_spec;
  dmsc_motor_t o_motor;
  dmsc_drive_t kd;
  int          err_count, checks, stores, steps;

  dmsc_top dmsc_top_i (
    .i_clk, .i_rst, .i_mode_wr, .i_mode_data, .i_cw_wr, .i_cw_data, .i_spec_act_wr,
    .i_spec_act_data, .i_spec_code_wr, .i_spec_code_data, .i_restart, .i_user_prog_run,
    .i_enc_present, .i_enc_has_index, .i_hall_present, .i_meas_valid, .i_meas_data,
    .i_index_seen, .o_meas_req, .i_pin_enable, .i_pin_clock, .i_pin_dir,
    .i_param_rd_addr, .o_param_rd_data, .o_status_word, .o_mode_eff, .o_spec, .o_motor,
    .o_coord_invalid, .o_store_req, .o_store_cat, .o_cfg_save_req
  );
  dmsc_master_model dmsc_master_model_i (
    .i_clk, .o_mode_wr(i_mode_wr), .o_mode_data(i_mode_data), .o_cw_wr(i_cw_wr),
    .o_cw_data(i_cw_data), .o_act_wr(i_spec_act_wr), .o_act_data(i_spec_act_data),
    .o_code_wr(i_spec_code_wr), .o_code_data(i_spec_code_data), .o_restart(i_restart),
    .o_user_prog_run(i_user_prog_run)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (o_store_req === 1'b1) stores++;
    if (o_motor.step === 1'b1) steps++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input int k, input logic [15:0] d);
    dmsc_master_model_i.put(k, d);
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic dmsc_drive_t kind_of(input logic [3:0] c);
    if (c[2]) return DRV_ANALOG;
    if (c[1]) return DRV_TEST_RUN;
    return DRV_CLKDIR;
  endfunction

  task automatic run_setup(input logic e, input logic x, input logic h, input logic ab);
    dmsc_meas_t q[$];
    int n;
    {i_enc_present, i_enc_has_index, i_hall_present} = {e, x, h};
    i_index_seen = 1'($urandom_range(1, 0));
    q = {MEAS_MOTOR_TYPE, MEAS_RESISTANCE, MEAS_INDUCTANCE, MEAS_FLUX};
    if (e && x) q = {q, MEAS_ENC_RES, MEAS_ALIGN};
    if (h) q.push_back(MEAS_HALL);
    wr(1, 16'h000f);
    wr(0, 16'(MODE_AUTOSETUP));
    wr(1, 16'h001f);
    n = stores;
    for (int i = 0; i < 20 && o_meas_req === MEAS_NONE; i++) cyc(1);
    foreach (q[i]) begin
      chk("meas_req", q[i], o_meas_req);
      if (ab && i == 2) begin
        wr(1, CW_STOP);
        break;
      end
      cyc($urandom_range(4, 1));
      par[q[i]] = $urandom();
      i_meas_data = par[q[i]];
      i_meas_valid = 1'b1;
      cyc(1);
      i_meas_valid = 1'b0;
    end
    cyc(8);
    chk("store_cycles", ab ? 0 : 2, stores - n);
    chk("setup_done", !ab, o_status_word[SW_SETUP_DONE_BIT]);
    if (ab) return;
    chk("index_found", e & x & i_index_seen, o_status_word[SW_INDEX_BIT]);
    chk("coord_invalid", 1, o_coord_invalid);
    foreach (q[i]) begin
      i_param_rd_addr = q[i];
      cyc(2);
      chk("param", par[q[i]], o_param_rd_data);
    end
    wr(4, 0);
    cyc(1);
    chk("coord_valid", 0, o_coord_invalid);
  endtask

  // Whole run is about a thousand cycles; 20000 cycles leaves wide margin
  initial begin
    #1000000;
    err_count++;
    print_verdict();
  end

  initial begin
    int n;
    void'($urandom(32'h4adac9dd));
    {i_meas_valid, i_index_seen, i_enc_present, i_enc_has_index, i_hall_present} = '0;
    {i_pin_enable, i_pin_clock, i_pin_dir, i_param_rd_addr, i_meas_data} = '0;
    i_rst = 1'b1;
    repeat (16) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    cyc(1);
    chk("meas_idle", MEAS_NONE, o_meas_req);
    chk("status", 16'h0000, o_status_word);
    for (int k = 0; k < 5; k++) begin
      run_setup(k[0], k[1], (k == 3) | 1'($urandom_range(1, 0)), k == 4);
    end
    wr(5, 1);
    wr(1, 16'h000f);
    wr(0, 16'(MODE_AUTOSETUP));
    wr(1, 16'h001f);
    cyc(4);
    chk("prog_block", MEAS_NONE, o_meas_req);
    wr(5, 0);
    wr(0, 16'(MODE_VELOCITY));
    wr(1, 16'h000f);
    wr(1, 16'h001f);
    cyc(4);
    chk("no_setup", MEAS_NONE, o_meas_req);
    chk("mode_eff", MODE_VELOCITY, o_mode_eff);
    chk("vel_run", 1, o_motor.enable);
    wr(1, CW_STOP);
    cyc(3);
    chk("vel_stop", 0, o_motor.enable);
    for (int c = 0; c < 16; c++) begin
      cv = 4'(c);
      kd = kind_of(cv);
      i_pin_dir = 1'($urandom_range(1, 0));
      wr(2, 16'(SPEC_ACTIVATE));
      wr(3, 16'(cv));
      // Low nibble differs, so a code that slips past the range check shows up
      wr(3, {8'h00, 4'h1, ~cv});
      wr(4, 0);
      cyc(1);
      chk("active", 1, o_spec.active);
      chk("closed_loop", cv[3], o_spec.closed_loop);
      chk("kind", kd, o_spec.kind);
      chk("joystick", cv[2] & cv[1], o_spec.joystick);
      if (kd == DRV_ANALOG)
        chk("max_rpm", cv[0] ? ANALOG_SLOW_RPM : ANALOG_FAST_RPM, o_spec.max_rpm);
      i_pin_enable = 1'b1;
      cyc(6);
      chk("op_enabled", 1, o_status_word[SW_OP_EN_BIT]);
      chk("motor_on", 1, o_motor.enable);
      chk("mode_eff", kd == DRV_CLKDIR ? MODE_CLKDIR : MODE_VELOCITY, o_mode_eff);
      if (kd == DRV_TEST_RUN) begin
        chk("dir_cw", !cv[0], o_motor.dir_cw);
        chk("rpm", TEST_RUN_RPM, o_motor.fixed_rpm);
      end else if (!cv[1]) begin
        chk("dir_cw", !i_pin_dir, o_motor.dir_cw);
      end
      wr(1, CW_STOP);
      cyc(2);
      chk("cw_ignored", 1, o_status_word[SW_OP_EN_BIT]);
      if (kd == DRV_CLKDIR) begin
        n = steps;
        repeat (3) begin
          i_pin_clock = 1'b1;
          cyc(4);
          i_pin_clock = 1'b0;
          cyc(4);
        end
        chk("steps", n + 3, steps);
      end
      i_pin_enable = 1'b0;
      cyc(6);
      chk("op_off", 0, o_status_word[SW_OP_EN_BIT]);
      chk("motor_off", 0, o_motor.enable);
    end
    wr(2, 0);
    wr(4, 0);
    cyc(1);
    chk("inactive", 0, o_spec.active);
    print_verdict();
  end
endmodule
`default_nettype wire
